// File: core/mbs_pkg.sv
// What this block does
// - Read query is address, function 3, start hi/lo, count hi/lo, CRC.
// - Read answer: address, function, byte count, 2*count data bytes, CRC.
// - Write query: address, func 16, start, count, byte count, data, CRC.
// - Write answer echoes address, function, start and count, then CRC.
// - Byte count is one byte, 0 to 255.
// - CRC bytes close each frame, high byte first then low byte.
// - CRC register starts at all ones before the first byte.
// - Each byte is XORed into the CRC register high byte.
// - Each step shifts right with zero fill, XOR 0xA001 if a one fell out.
// - Eight steps per byte, all bytes in turn, final value is the CRC.
// - An 8-bit value sits in the low or high byte of a register.
// - A 16-bit value fills one whole register.
// - 32-bit integer is sign-magnitude over two registers, sign in bit 31.
// - Float is IEEE single: sign 31, exponent 30..23, mantissa 22..0.
// - Float spans two registers, sign/exponent register is the high one.
// - Float negative zero is a marker, not a number.
// - Exponent carries a bias of 127; mantissa drops its leading one.
// - Multidrop ports delay each answer by a response time, 1 ms default.
package mbs_pkg;
  localparam int BYTE_W = 8;
  localparam int WORD_W = 16;
  localparam logic [7:0] FN_READ = 8'h03;
  localparam logic [7:0] FN_WRITE = 8'h10;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'hA001;
  localparam int CRC_STEPS = 8;
  localparam logic [7:0] MAX_REGS = 8'h7F;
  localparam int BUF_W = 7;
  localparam int FIFO_DEPTH = 16;
  localparam logic [2:0] RD_HDR_LAST = 3'h2;
  localparam logic [2:0] WR_HDR_LAST = 3'h5;
  localparam int SIGN_BIT = 31;
  localparam int EXP_HI = 30;
  localparam int EXP_LO = 23;
  localparam int MAN_HI = 22;
  localparam logic [8:0] EXP_BIAS = 9'h07F;
  localparam logic [31:0] FLOAT_NEG_ZERO = 32'h80000000;
  localparam int CLK_HZ = 10_000_000;
  localparam int RESP_DELAY_US = 1000;
  localparam int RESP_DELAY_CYC = RESP_DELAY_US * (CLK_HZ / 1_000_000);
  localparam int DLY_W = 16;

  // One byte through the bit-serial CRC
  function automatic logic [15:0] crc_byte(input logic [15:0] c,
                                           input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {b, 8'h00};
    for (int i = 0; i < CRC_STEPS; i++) begin
      if (r[0]) begin
        r = (r >> 1) ^ CRC_POLY;
      end else begin
        r = r >> 1;
      end
    end
    return r;
  endfunction : crc_byte

  // Unbiased exponent of a float word
  function automatic logic signed [8:0] f_exp(input logic [31:0] w);
    return $signed({1'b0, w[EXP_HI:EXP_LO]}) - $signed(EXP_BIAS);
  endfunction : f_exp
endpackage : mbs_pkg

// File: core/mbs_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module mbs_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } mbs_fifo_t;
  mbs_fifo_t s_r, s_nxt;
  logic push, pop;

  assign in_ready = (s_r.cnt != DEPTH[AW:0]);
  assign out_valid = (s_r.cnt != '0);
  assign out_data = s_r.mem[s_r.rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    s_nxt = s_r;
    if (push) begin
      s_nxt.mem[s_r.wp] = in_data;
      s_nxt.wp = s_r.wp + 1'b1;
    end
    if (pop) begin
      s_nxt.rp = s_r.rp + 1'b1;
    end
    s_nxt.cnt = s_r.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule : mbs_fifo
`default_nettype wire

// File: core/mbs_frame.sv
`timescale 1ns/1ps
`default_nettype none
module mbs_frame #(
  parameter int RESP_DELAY_CYCLES = mbs_pkg::RESP_DELAY_CYC
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] dev_addr,
  input wire logic multidrop,
  input wire logic rx_valid,
  input wire logic rx_first,
  input wire logic [7:0] rx_data,
  output logic tx_valid,
  output logic [7:0] tx_data,
  input wire logic tx_ready,
  output logic reg_wr,
  output logic reg_rd,
  output logic [15:0] reg_addr,
  output logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  output logic busy,
  output logic drop,
  output logic [31:0] pair_word,
  output logic signed [8:0] pair_exp,
  output logic pair_marker
);
  import mbs_pkg::*;

  // ==========================================================
  // State
  typedef enum logic [4:0] {
    S_ADDR, S_FUNC, S_SAH, S_SAL, S_CNH, S_CNL, S_BCNT, S_DATA,
    S_CKH, S_CKL, S_DELAY, S_HDR, S_RDREQ, S_RDWAIT, S_DHI, S_DLO,
    S_WR, S_TXCH, S_TXCL
  } mbs_st_t;

  typedef struct packed {
    mbs_st_t st;
    logic [7:0] addr;
    logic [7:0] func;
    logic [15:0] start;
    logic [15:0] count;
    logic [7:0] bcnt;
    logic [7:0] idx;
    logic [7:0] hold;
    logic [15:0] crc;
    logic [15:0] txcrc;
    logic [15:0] word;
    logic [2:0] hidx;
    logic [DLY_W-1:0] dly;
    logic [(1<<BUF_W)-1:0][15:0] buf_w;
    logic reg_wr;
    logic reg_rd;
    logic [15:0] reg_addr;
    logic [15:0] reg_wdata;
    logic drop;
    logic [31:0] pair_word;
    logic signed [8:0] pair_exp;
    logic pair_marker;
  } mbs_state_t;

  mbs_state_t s_r, s_nxt;
  logic push_valid, push_ready;
  logic [7:0] push_data;
  logic [15:0] rx_crc;
  logic hdr_last;
  logic [31:0] pair;

  // ==========================================================
  // Answer buffer
  // Back-pressure from the link stalls the emit states
  mbs_fifo #(.WIDTH(BYTE_W), .DEPTH(FIFO_DEPTH)) mbs_fifo_i (
    .clk(clk),
    .reset(reset),
    .in_valid(push_valid),
    .in_data(push_data),
    .in_ready(push_ready),
    .out_valid(tx_valid),
    .out_data(tx_data),
    .out_ready(tx_ready)
  );

  // Header byte for the answer
  function automatic logic [7:0] hdr_byte(input mbs_state_t s);
    unique case (s.hidx)
      3'h0: return s.addr;
      3'h1: return s.func;
      3'h2: return (s.func == FN_READ) ? s.bcnt : s.start[15:8];
      3'h3: return s.start[7:0];
      3'h4: return s.count[15:8];
      default: return s.count[7:0];
    endcase
  endfunction : hdr_byte

  assign hdr_last = (s_r.hidx == ((s_r.func == FN_READ) ?
                     RD_HDR_LAST : WR_HDR_LAST));
  assign rx_crc = (rx_valid && rx_first) ? crc_byte(CRC_INIT, rx_data)
                  : crc_byte(s_r.crc, rx_data);
  assign pair = {s_r.buf_w[s_r.idx[BUF_W-1:0] - 1'b1],
                 s_r.buf_w[s_r.idx[BUF_W-1:0]]};

  always_comb begin
    push_valid = 1'b0;
    push_data = 8'h00;
    unique case (s_r.st)
      S_HDR: begin
        push_valid = 1'b1;
        push_data = hdr_byte(s_r);
      end
      S_DHI: begin
        push_valid = 1'b1;
        push_data = s_r.word[15:8];
      end
      S_DLO: begin
        push_valid = 1'b1;
        push_data = s_r.word[7:0];
      end
      S_TXCH: begin
        push_valid = 1'b1;
        push_data = s_r.txcrc[15:8];
      end
      S_TXCL: begin
        push_valid = 1'b1;
        push_data = s_r.txcrc[7:0];
      end
      default: begin
        push_valid = 1'b0;
      end
    endcase
  end

  // ==========================================================
  // Parser and responder
  always_comb begin
    s_nxt = s_r;
    s_nxt.reg_wr = 1'b0;
    s_nxt.reg_rd = 1'b0;
    s_nxt.drop = 1'b0;
    s_nxt.pair_marker = 1'b0;
    if (push_valid && push_ready) begin
      s_nxt.txcrc = crc_byte(s_r.txcrc, push_data);
    end
    if (rx_valid && rx_first && s_r.st < S_DELAY) begin
      // A frame start resynchronises the parser, except while an answer is under way (S_DELAY or later)
      s_nxt.addr = rx_data;
      s_nxt.crc = rx_crc;
      s_nxt.st = S_FUNC;
    end else if (rx_valid && s_r.st < S_DELAY) begin
      s_nxt.crc = rx_crc;
      unique case (s_r.st)
        S_ADDR: begin
          s_nxt.addr = rx_data;
          s_nxt.crc = crc_byte(CRC_INIT, rx_data);
          s_nxt.st = S_FUNC;
        end
        S_FUNC: begin
          s_nxt.func = rx_data;
          s_nxt.st = S_SAH;
        end
        S_SAH: begin
          s_nxt.start[15:8] = rx_data;
          s_nxt.st = S_SAL;
        end
        S_SAL: begin
          s_nxt.start[7:0] = rx_data;
          s_nxt.st = S_CNH;
        end
        S_CNH: begin
          s_nxt.count[15:8] = rx_data;
          s_nxt.st = S_CNL;
        end
        S_CNL: begin
          s_nxt.count[7:0] = rx_data;
          s_nxt.idx = 8'h00;
          s_nxt.bcnt = {rx_data[6:0], 1'b0};
          s_nxt.st = (s_r.func == FN_WRITE) ? S_BCNT : S_CKH;
        end
        S_BCNT: begin
          s_nxt.bcnt = rx_data;
          s_nxt.st = (rx_data == 8'h00) ? S_CKH : S_DATA;
        end
        S_DATA: begin
          if (!s_r.idx[0]) begin
            s_nxt.hold = rx_data;
          end else begin
            s_nxt.buf_w[s_r.idx[BUF_W:1]] = {s_r.hold, rx_data};
          end
          s_nxt.idx = s_r.idx + 8'h01;
          if (s_r.idx + 8'h01 == s_r.bcnt) begin
            s_nxt.st = S_CKH;
          end
        end
        S_CKH: begin
          s_nxt.crc = s_r.crc;
          s_nxt.hold = rx_data;
          s_nxt.st = S_CKL;
        end
        default: begin
          // S_CKL: whole query in hand
          s_nxt.crc = s_r.crc;
          s_nxt.idx = 8'h00;
          s_nxt.hidx = 3'h0;
          s_nxt.dly = multidrop ? DLY_W'(RESP_DELAY_CYCLES) : '0;
          s_nxt.st = S_DELAY;
          if ({s_r.hold, rx_data} != s_r.crc
              || s_r.addr != dev_addr
              || (s_r.func != FN_READ && s_r.func != FN_WRITE)
              || s_r.count == 16'h0000 || s_r.count > {8'h00, MAX_REGS}
              || (s_r.func == FN_WRITE
                  && s_r.bcnt != {s_r.count[6:0], 1'b0})) begin
            s_nxt.drop = 1'b1;
            s_nxt.st = S_ADDR;
          end
        end
      endcase
    end else begin
      unique case (s_r.st)
        S_DELAY: begin
          s_nxt.txcrc = CRC_INIT;
          if (s_r.dly <= DLY_W'(1)) begin
            s_nxt.st = (s_r.func == FN_WRITE) ? S_WR : S_HDR;
          end else begin
            s_nxt.dly = s_r.dly - 1'b1;
          end
        end
        S_WR: begin
          // Registers change only once the CRC has been checked
          s_nxt.reg_wr = 1'b1;
          s_nxt.reg_addr = s_r.start + {8'h00, s_r.idx};
          s_nxt.reg_wdata = s_r.buf_w[s_r.idx[BUF_W-1:0]];
          if (s_r.idx[0]) begin
            s_nxt.pair_word = pair;
            s_nxt.pair_exp = f_exp(pair);
            s_nxt.pair_marker = (pair == FLOAT_NEG_ZERO);
          end
          s_nxt.idx = s_r.idx + 8'h01;
          if (s_r.idx + 8'h01 == s_r.count[7:0]) begin
            s_nxt.st = S_HDR;
          end
        end
        S_HDR: begin
          if (push_ready) begin
            s_nxt.hidx = s_r.hidx + 3'h1;
            if (hdr_last) begin
              s_nxt.idx = 8'h00;
              s_nxt.st = (s_r.func == FN_READ) ? S_RDREQ : S_TXCH;
            end
          end
        end
        S_RDREQ: begin
          s_nxt.reg_rd = 1'b1;
          s_nxt.reg_addr = s_r.start + {8'h00, s_r.idx};
          s_nxt.st = S_RDWAIT;
        end
        S_RDWAIT: begin
          s_nxt.word = reg_rdata;
          s_nxt.st = S_DHI;
        end
        S_DHI: begin
          if (push_ready) begin
            s_nxt.st = S_DLO;
          end
        end
        S_DLO: begin
          if (push_ready) begin
            s_nxt.idx = s_r.idx + 8'h01;
            s_nxt.st = (s_r.idx + 8'h01 == s_r.count[7:0]) ?
                       S_TXCH : S_RDREQ;
          end
        end
        S_TXCH: begin
          // Low byte must come from the same finished CRC value
          s_nxt.txcrc = s_r.txcrc;
          if (push_ready) begin
            s_nxt.st = S_TXCL;
          end
        end
        S_TXCL: begin
          if (push_ready) begin
            s_nxt.st = S_ADDR;
          end
        end
        default: begin
          s_nxt.st = s_r.st;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s_r <= '0;
      s_r.st <= S_ADDR;
      s_r.crc <= CRC_INIT;
      s_r.txcrc <= CRC_INIT;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign reg_wr = s_r.reg_wr;
  assign reg_rd = s_r.reg_rd;
  assign reg_addr = s_r.reg_addr;
  assign reg_wdata = s_r.reg_wdata;
  assign busy = (s_r.st >= S_DELAY);
  assign drop = s_r.drop;
  assign pair_word = s_r.pair_word;
  assign pair_exp = s_r.pair_exp;
  assign pair_marker = s_r.pair_marker;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  crc_start_a: assert property (
    rx_valid && rx_first && !busy |=> s_r.crc == crc_byte(16'hFFFF,
                                                $past(rx_data)))
    else $error("CRC not seeded from all ones");
  wr_func_a: assert property (reg_wr |-> s_r.func == FN_WRITE)
    else $error("register write outside function 16");
  rd_func_a: assert property (reg_rd |-> s_r.func == FN_READ)
    else $error("register read outside function 3");
  rd_seq_a: assert property (
    reg_rd |-> s_r.st == S_RDWAIT ##1 s_r.st == S_DHI)
    else $error("read data not captured one cycle after request");
  crc_order_a: assert property (
    s_r.st == S_TXCH && push_ready |=> s_r.st == S_TXCL
      && $past(push_data) == $past(s_r.txcrc[15:8])
      && s_r.txcrc == $past(s_r.txcrc))
    else $error("CRC high byte not sent first");
  bcnt_val_a: assert property (
    s_r.st == S_HDR && s_r.func == FN_READ && s_r.hidx == 3'h2
      |-> push_data == {s_r.count[6:0], 1'b0})
    else $error("read byte count not twice the register count");
  wr_echo_a: assert property (
    s_r.st == S_HDR && s_r.func == FN_WRITE && s_r.hidx == 3'h5
      && push_ready |=> s_r.st == S_TXCH)
    else $error("write answer carries more than the echo");
  bad_drop_a: assert property (
    s_r.st == S_CKL && rx_valid && !rx_first
      && {s_r.hold, rx_data} != s_r.crc |=> drop && s_r.st == S_ADDR)
    else $error("query with bad CRC not dropped");
  delay_hold_a: assert property (
    s_r.st == S_DELAY && s_r.dly > DLY_W'(1) |=> s_r.st == S_DELAY)
    else $error("answer started before the response delay");
  marker_a: assert property (
    pair_marker |-> pair_word == 32'h80000000)
    else $error("marker raised for a non negative-zero pair");

  read_done_c: cover property (s_r.st == S_TXCL && s_r.func == FN_READ
                               && push_ready);
  write_done_c: cover property (s_r.st == S_TXCL && s_r.func == FN_WRITE
                                && push_ready);
  drop_c: cover property (drop);
  stall_c: cover property (push_valid && !push_ready);
endmodule : mbs_frame
`default_nettype wire

// File: bench/mbs_master.sv
`timescale 1ns/1ps
`default_nettype none
// =====
// Serial master: sends queries, collects answers
module mbs_master (
  input wire logic clk,
  input wire logic reset,
  input wire logic stall,
  output logic rx_valid,
  output logic rx_first,
  output logic [7:0] rx_data,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready
);
  logic [7:0] got[$];

  function automatic logic [15:0] crc16(input logic [7:0] q[$]);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (q[i]) begin
      c = c ^ {q[i], 8'h00};
      repeat (8) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
    end
    return c;
  endfunction : crc16

  // A set bad flag flips the CRC low bit
  task automatic send(input logic [7:0] q[$], input bit bad);
    logic [15:0] c;
    c = crc16(q) ^ {15'h0, bad};
    q.push_back(c[15:8]);
    q.push_back(c[7:0]);
    foreach (q[i]) begin
      @(posedge clk);
      #1;
      rx_valid = 1'b1;
      rx_first = (i == 0);
      rx_data = q[i];
    end
    @(posedge clk);
    #1;
    rx_valid = 1'b0;
    rx_first = 1'b0;
    // Released line shows no stale byte
    rx_data = ~rx_data;
  endtask : send

  initial begin
    rx_valid = 1'b0;
    rx_first = 1'b0;
    rx_data = 8'h00;
    tx_ready = 1'b0;
  end
  always @(posedge clk) begin
    tx_ready <= #1 ~stall & ~reset;
    if (tx_valid && tx_ready) got.push_back(tx_data);
  end
endmodule : mbs_master
`default_nettype wire

// File: bench/mbs_frame_test.sv
`timescale 1ns/1ps
`default_nettype none
module mbs_frame_test;
  import mbs_pkg::*;
  localparam int DLY = 5;
  logic clk, reset, multidrop, stall, rx_valid, rx_first;
  logic tx_valid, tx_ready, reg_wr, reg_rd, busy, drop, pair_marker;
  logic [7:0] dev_addr, rx_data, tx_data;
  logic [15:0] reg_addr, reg_wdata, reg_rdata;
  logic [31:0] pair_word, seed;
  logic signed [8:0] pair_exp;
  logic [15:0] mem [0:65535];
  logic [15:0] wfix[$];
  int error_cnt, n_checks, n_wr, n_drop, n_mark, lvl;

  mbs_frame #(.RESP_DELAY_CYCLES(DLY)) mbs_frame_i (.clk(clk),
    .reset(reset), .dev_addr(dev_addr), .multidrop(multidrop),
    .rx_valid(rx_valid), .rx_first(rx_first), .rx_data(rx_data),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .busy(busy),
    .drop(drop), .pair_word(pair_word), .pair_exp(pair_exp),
    .pair_marker(pair_marker));
  mbs_master mbs_master_i (.clk(clk), .reset(reset), .stall(stall),
    .rx_valid(rx_valid), .rx_first(rx_first), .rx_data(rx_data),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));

  function automatic logic [15:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[15:0];
  endfunction : rnd

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  task automatic stop_test();
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : stop_test

  // =====
  // Register file and event counters
  always @(posedge clk) begin
    if (reg_wr) mem[reg_addr] <= reg_wdata;
    n_wr <= n_wr + int'(reg_wr);
    n_drop <= n_drop + int'(drop);
    n_mark <= n_mark + int'(pair_marker);
    stall <= #1 (rnd() % 4) < lvl;
  end

  // Read data valid only while reg_rd stands; taken at its first edge
  always @(reg_rd, reg_addr) begin
    reg_rdata = reg_rd ? mem[reg_addr] : ~mem[reg_addr];
  end

  // =====
  // One query and its expected answer
  task automatic xact(input logic [7:0] a, input logic [7:0] f,
      input logic [15:0] st, input logic [15:0] n, input bit bad,
      input bit ok);
    logic [7:0] q[$], e[$];
    logic [15:0] wd[$];
    logic [15:0] w, c, idx;
    logic signed [8:0] x;
    int t, d0, w0, m0;
    q = {a, f, st[15:8], st[7:0], n[15:8], n[7:0]};
    e = q;
    if (f == FN_WRITE) begin
      q.push_back(8'(2 * n));
      for (int i = 0; i < n; i++) begin
        w = rnd();
        if (wfix.size() > 0) w = wfix.pop_front();
        wd.push_back(w);
        q.push_back(w[15:8]);
        q.push_back(w[7:0]);
      end
    end else begin
      e = {a, f, 8'(2 * n)};
      for (int i = 0; i < n; i++) begin
        idx = st + 16'(i);
        e.push_back(mem[idx][15:8]);
        e.push_back(mem[idx][7:0]);
      end
    end
    c = mbs_master_i.crc16(e);
    e.push_back(c[15:8]);
    e.push_back(c[7:0]);
    if (!ok) e.delete();
    mbs_master_i.got.delete();
    d0 = n_drop;
    w0 = n_wr;
    m0 = n_mark;
    mbs_master_i.send(q, bad);
    chk(32'(busy), 32'(ok));
    if (multidrop) repeat (DLY - 1) begin
      @(posedge clk);
      chk(32'(tx_valid), 32'h0);
    end
    for (t = 0; t < 4000; t++) begin
      @(posedge clk);
      if (ok ? mbs_master_i.got.size() >= e.size() : n_drop != d0) break;
    end
    chk(32'(t < 4000), 32'h1);
    repeat (20) @(posedge clk);
    chk(32'(busy), 32'h0);
    chk(mbs_master_i.got.size(), e.size());
    foreach (e[i]) chk(mbs_master_i.got[i], e[i]);
    if (!ok) chk(n_drop - d0, 1);
    chk(n_wr - w0, (ok && f == FN_WRITE) ? n : 0);
    if (ok && f == FN_WRITE) begin
      foreach (wd[i]) chk(mem[st + 16'(i)], wd[i]);
      if (n % 2 == 0) begin
        w = wd[n - 1];
        c = wd[n - 2];
        x = $signed({1'b0, c[14:7]}) - 9'sd127;
        chk(pair_word, {c, w});
        chk(32'(pair_exp), 32'(x));
        chk(n_mark - m0, int'({c, w} == 32'h80000000));
      end
    end
  endtask : xact

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    repeat (60000) @(posedge clk);
    error_cnt++;
    stop_test();
  end

  initial begin
    seed = 32'd71;
    reset = 1'b1;
    dev_addr = 8'h11;
    multidrop = 1'b0;
    stall = 1'b0;
    lvl = 0;
    foreach (mem[i]) mem[i] = 16'(i * 40503);
    repeat (10) @(posedge clk);
    #1;
    reset = 1'b0;
    xact(8'h11, FN_WRITE, 16'h0332, 16'd8, 0, 1);
    lvl = 2;
    xact(8'h11, FN_READ, 16'h012C, 16'd18, 0, 1);
    repeat (6) xact(8'h11, (rnd() % 2) ? FN_READ : FN_WRITE, rnd(),
      16'(rnd() % 8 + 1), 0, 1);
    wfix = {16'h0000, 16'h0000, 16'h8000, 16'h0000};
    xact(8'h11, FN_WRITE, 16'h0100, 16'd4, 0, 1);
    xact(8'h11, FN_WRITE, 16'h0200, 16'd2, 1, 0);
    xact(8'h12, FN_READ, 16'h0200, 16'd2, 0, 0);
    xact(8'h11, 8'h04, 16'h0200, 16'd2, 0, 0);
    xact(8'h11, FN_READ, 16'h0200, 16'd0, 0, 0);
    xact(8'h11, FN_READ, 16'h0200, 16'd128, 0, 0);
    lvl = 3;
    xact(8'h11, FN_READ, 16'hFFC0, 16'd127, 0, 1);
    lvl = 1;
    multidrop = 1'b1;
    xact(8'h11, FN_WRITE, 16'h0040, 16'd2, 0, 1);
    xact(8'h11, FN_READ, 16'h0040, 16'd3, 0, 1);
    stop_test();
  end
endmodule : mbs_frame_test
`default_nettype wire
